/* rtl/mpzc_top.sv */
// Memory power and zeroization control: two registers on a classic Wishbone slave that drive
// retention enables, wait states and five clearing engines.
// Assumes the memory arrays honour the retention and wait-state levels and take zero writes.
`timescale 1ns/10ps
`include "mpzc_defs.svh"
module mpzc_top (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`MPZC_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic rom_retention_enable,
    output logic icache_retention_enable,
    output logic sram_pair_d_retention_enable,
    output logic sram_pair_c_retention_enable,
    output logic sram_pair_b_retention_enable,
    output logic sram_pair_a_retention_enable,
    output logic sram_wait_state_enable,
    output logic [2:0] flash_wait_states,
    output logic sram_bank_a_zero_we,
    output logic [`MPZC_CLR_ADR_W-1:0] sram_bank_a_zero_addr,
    output logic sram_bank_b_zero_we,
    output logic [`MPZC_CLR_ADR_W-1:0] sram_bank_b_zero_addr,
    output logic sram_bank_c_zero_we,
    output logic [`MPZC_CLR_ADR_W-1:0] sram_bank_c_zero_addr,
    output logic checkbit_zero_we,
    output logic [`MPZC_CLR_ADR_W-1:0] checkbit_zero_addr,
    output logic icache_zero_we,
    output logic [`MPZC_CLR_ADR_W-1:0] icache_zero_addr
);
    function automatic logic reg_hit(input logic [`MPZC_ADR_W-1:0] adr,
                                     input logic [`MPZC_ADR_W-1:0] ofs);
        reg_hit = (adr == ofs);
    endfunction : reg_hit

    // A write reaches a field only with its byte lane set and its register addressed.
    function automatic logic lane_write(input logic commit,
                                        input logic lane,
                                        input logic [`MPZC_ADR_W-1:0] adr,
                                        input logic [`MPZC_ADR_W-1:0] ofs);
        lane_write = commit && lane && reg_hit(adr, ofs);
    endfunction : lane_write

    logic [5:0] retention;
    logic ram_ws;
    logic [2:0] fws;
    logic [`MPZC_Z_COUNT-1:0] clear_start;
    logic [`MPZC_Z_COUNT-1:0] clear_busy;
    logic req;
    logic wr_commit;
    logic [31:0] next_rdata;
    logic clk_lane0_wr;
    logic clk_lane1_wr;
    logic zero_lane0_wr;

    assign req = wb_cyc_i && wb_stb_i;
    // Writes land on the edge where the master sees ack, never earlier.
    assign wr_commit = req && wb_we_i && wb_ack_o;

    // Each byte lane gates its own fields, so a narrow write leaves the other fields alone.
    assign clk_lane1_wr = lane_write(wr_commit, wb_sel_i[1], wb_adr_i, `MPZC_CLK_CTRL_OFS);
    assign clk_lane0_wr = lane_write(wr_commit, wb_sel_i[0], wb_adr_i, `MPZC_CLK_CTRL_OFS);
    assign zero_lane0_wr = lane_write(wr_commit, wb_sel_i[0], wb_adr_i, `MPZC_ZERO_CTRL_OFS);

    // One wait cycle, then ack for one cycle; ack drops the cycle after it was given.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req && !wb_ack_o;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000; // [RULE9]
        if (reg_hit(wb_adr_i, `MPZC_CLK_CTRL_OFS)) begin
            next_rdata[`MPZC_RET_MSB:`MPZC_RET_LSB] = retention;
            next_rdata[`MPZC_RAMWS_BIT] = ram_ws;
            next_rdata[`MPZC_FWS_MSB:`MPZC_FWS_LSB] = fws;
        end else if (reg_hit(wb_adr_i, `MPZC_ZERO_CTRL_OFS)) begin
            next_rdata[`MPZC_Z_COUNT-1:0] = clear_busy; // [RULE6] [RULE7] [RULE8]
        end
    end

    // Unmapped addresses are acknowledged and read as zero.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_ack_o) begin
            wb_dat_o <= next_rdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            retention <= `MPZC_RET_RESET; // [RULE1]
        end else if (clk_lane1_wr) begin
            retention <= wb_dat_i[`MPZC_RET_MSB:`MPZC_RET_LSB]; // [RULE1]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ram_ws <= `MPZC_RAMWS_RESET; // [RULE4]
        end else if (clk_lane0_wr) begin
            ram_ws <= wb_dat_i[`MPZC_RAMWS_BIT]; // [RULE4]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            fws <= `MPZC_FWS_RESET; // [RULE5]
        end else if (clk_lane0_wr) begin
            fws <= wb_dat_i[`MPZC_FWS_MSB:`MPZC_FWS_LSB]; // [RULE5]
        end
    end

    // A zero bit leaves its engine alone; a one starts it unless it already runs.
    always_comb begin
        clear_start = '0;
        if (zero_lane0_wr) begin
            clear_start = wb_dat_i[`MPZC_Z_COUNT-1:0]; // [RULE9]
        end
    end

    // Level outputs toward the arrays are registered here so they leave straight from flops.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rom_retention_enable <= 1'b0;
            icache_retention_enable <= 1'b0;
            sram_pair_d_retention_enable <= 1'b0;
            sram_pair_c_retention_enable <= 1'b0;
            sram_pair_b_retention_enable <= 1'b0;
            sram_pair_a_retention_enable <= 1'b0;
        end else begin
            rom_retention_enable <= retention[5]; // [RULE2]
            icache_retention_enable <= retention[4]; // [RULE2]
            sram_pair_d_retention_enable <= retention[3]; // [RULE2]
            sram_pair_c_retention_enable <= retention[2]; // [RULE2]
            sram_pair_b_retention_enable <= retention[1]; // [RULE2]
            sram_pair_a_retention_enable <= retention[0]; // [RULE3]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sram_wait_state_enable <= `MPZC_RAMWS_RESET;
        end else begin
            sram_wait_state_enable <= ram_ws; // [RULE4]
        end
    end

    // The arrays see a new flash setting one cycle after the register takes it.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flash_wait_states <= `MPZC_FWS_RESET;
        end else begin
            flash_wait_states <= fws; // [RULE5]
        end
    end

    // Each engine runs alone; a start that reaches a busy engine is dropped inside it.

    mpzc_zeroizer #(
        .WORDS(`MPZC_SRAM_BANK_WORDS)
    ) u_zero_sram_a (
        .sys_clk(sys_clk),
        .srst(srst),
        .start(clear_start[`MPZC_Z_SRAM_A]), // [RULE6]
        .busy(clear_busy[`MPZC_Z_SRAM_A]),
        .zero_we(sram_bank_a_zero_we),
        .zero_addr(sram_bank_a_zero_addr)
    );

    mpzc_zeroizer #(
        .WORDS(`MPZC_SRAM_BANK_WORDS)
    ) u_zero_sram_b (
        .sys_clk(sys_clk),
        .srst(srst),
        .start(clear_start[`MPZC_Z_SRAM_B]), // [RULE6]
        .busy(clear_busy[`MPZC_Z_SRAM_B]),
        .zero_we(sram_bank_b_zero_we),
        .zero_addr(sram_bank_b_zero_addr)
    );

    mpzc_zeroizer #(
        .WORDS(`MPZC_SRAM_BANK_WORDS)
    ) u_zero_sram_c (
        .sys_clk(sys_clk),
        .srst(srst),
        .start(clear_start[`MPZC_Z_SRAM_C]), // [RULE6]
        .busy(clear_busy[`MPZC_Z_SRAM_C]),
        .zero_we(sram_bank_c_zero_we),
        .zero_addr(sram_bank_c_zero_addr)
    );

    mpzc_zeroizer #(
        .WORDS(`MPZC_CHECKBIT_WORDS)
    ) u_zero_checkbits (
        .sys_clk(sys_clk),
        .srst(srst),
        .start(clear_start[`MPZC_Z_CHECKBITS]), // [RULE8]
        .busy(clear_busy[`MPZC_Z_CHECKBITS]),
        .zero_we(checkbit_zero_we),
        .zero_addr(checkbit_zero_addr)
    );

    // Data and tag arrays share one index, so one engine clears both in step.
    mpzc_zeroizer #(
        .WORDS(`MPZC_ICACHE_WORDS)
    ) u_zero_icache (
        .sys_clk(sys_clk),
        .srst(srst),
        .start(clear_start[`MPZC_Z_ICACHE]), // [RULE7]
        .busy(clear_busy[`MPZC_Z_ICACHE]),
        .zero_we(icache_zero_we),
        .zero_addr(icache_zero_addr)
    );
endmodule : mpzc_top

/* rtl/mpzc_defs.svh */
// Register map, field positions, reset values and clearing lengths of the memory power and
// zeroization control block. Assumes a 32-bit Wishbone slave decoding byte addresses.
//
// Behaviour
// RULE1: Retention enables in bits 13:8 reset to 0; 1 keeps data, blocks access.
// RULE2: Bit 11 pairs banks 3/7, 10 pairs 2/6, 9 pairs 1/5, 13 ROM, 12 icache.
// RULE3: Bit 8 puts banks 0 and 4 together into retention.
// RULE4: RAM wait-state bit 4 resets to 1; 1 adds one wait state per access.
// RULE5: Flash wait-state field bits 2:0 resets to 5, range 0 to 7.
// RULE6: Writing 1 to bit 0, 1 or 2 clears that RAM bank; reads 1 while busy.
// RULE7: Writing 1 to bit 4 clears icache data and tags; reads 1 while busy.
// RULE8: Writing 1 to bit 3 clears RAM check bits; reads 1 while busy.
// RULE9: Writing 0 to zeroize bits does nothing; reserved bits read 0.
`ifndef MPZC_DEFS_SVH
`define MPZC_DEFS_SVH

`define MPZC_ADR_W 8
`define MPZC_CLK_CTRL_OFS 8'h28
`define MPZC_ZERO_CTRL_OFS 8'h2c

`define MPZC_FWS_LSB 0
`define MPZC_FWS_MSB 2
`define MPZC_FWS_RESET 3'h5
`define MPZC_RAMWS_BIT 4
`define MPZC_RAMWS_RESET 1'h1
`define MPZC_RET_LSB 8
`define MPZC_RET_MSB 13
`define MPZC_RET_RESET 6'h00

`define MPZC_Z_SRAM_A 0
`define MPZC_Z_SRAM_B 1
`define MPZC_Z_SRAM_C 2
`define MPZC_Z_CHECKBITS 3
`define MPZC_Z_ICACHE 4
`define MPZC_Z_COUNT 5

`define MPZC_CLR_ADR_W 16
`define MPZC_SRAM_BANK_WORDS 16'h2000
`define MPZC_CHECKBIT_WORDS 16'h6000
`define MPZC_ICACHE_WORDS 16'h0400

`endif

/* rtl/mpzc_pkg.sv */
// Types shared by the memory power and zeroization control block.
// Assumes the constants header is included by the files that use it.
package mpzc_pkg;
    typedef enum logic [1:0] {
        MPZC_IDLE = 2'b01,
        MPZC_CLEAR = 2'b10
    } mpzc_state_e;
endpackage : mpzc_pkg

/* rtl/mpzc_zeroizer.sv */
// One clearing engine: walks an array from word 0 upward, writing zeros, then goes idle.
// Assumes the array takes one zero write per clock while zero_we is high.
`timescale 1ns/10ps
`include "mpzc_defs.svh"
module mpzc_zeroizer #(
    parameter logic [`MPZC_CLR_ADR_W-1:0] WORDS = `MPZC_SRAM_BANK_WORDS
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic start,
    output logic busy,
    output logic zero_we,
    output logic [`MPZC_CLR_ADR_W-1:0] zero_addr
);
    mpzc_pkg::mpzc_state_e state;
    logic last_word;

    assign last_word = (zero_addr == WORDS - 16'h0001);

    // A start while busy is dropped, so a second request cannot restart a half-done pass.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= mpzc_pkg::MPZC_IDLE;
        end else begin
            unique case (state)
                mpzc_pkg::MPZC_IDLE: begin
                    if (start) begin
                        state <= mpzc_pkg::MPZC_CLEAR;
                    end
                end
                mpzc_pkg::MPZC_CLEAR: begin
                    if (last_word) begin
                        state <= mpzc_pkg::MPZC_IDLE;
                    end
                end
                default: begin
                    state <= mpzc_pkg::MPZC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            zero_addr <= '0;
        end else if (state == mpzc_pkg::MPZC_CLEAR && !last_word) begin
            zero_addr <= zero_addr + 16'h0001;
        end else if (state == mpzc_pkg::MPZC_IDLE) begin
            zero_addr <= '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            busy <= 1'b0;
            zero_we <= 1'b0;
        end else if (state == mpzc_pkg::MPZC_IDLE) begin
            busy <= start;
            zero_we <= start;
        end else begin
            busy <= !last_word;
            zero_we <= !last_word;
        end
    end
endmodule : mpzc_zeroizer

/* verification/mpzc_props.sv */
// Checker for the register and zeroize behaviour of the memory power control block.
// Assumes it is bound to mpzc_top and sees only that module's ports.
`timescale 1ns/10ps
`include "mpzc_defs.svh"
module mpzc_props (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic wb_we_i,
    input wire logic [`MPZC_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic sram_pair_a_retention_enable,
    input wire logic sram_wait_state_enable,
    input wire logic [2:0] flash_wait_states,
    input wire logic sram_bank_a_zero_we,
    input wire logic [`MPZC_CLR_ADR_W-1:0] sram_bank_a_zero_addr
);
    logic w28;
    logic w2c;
    logic rd;
    assign w28 = wb_ack_o && wb_we_i && wb_adr_i == `MPZC_CLK_CTRL_OFS;
    assign w2c = wb_ack_o && wb_we_i && wb_adr_i == `MPZC_ZERO_CTRL_OFS && wb_sel_i[0];
    assign rd = wb_ack_o && !wb_we_i;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    a_ret_pair_a: assert property (w28 && wb_sel_i[1] |=> ##1
        sram_pair_a_retention_enable == $past(wb_dat_i[8], 2)) else $error("retention bit");
    a_ram_wait: assert property (w28 && wb_sel_i[0] |=> ##1
        sram_wait_state_enable == $past(wb_dat_i[4], 2)) else $error("ram wait bit");
    a_flash_wait: assert property (w28 && wb_sel_i[0] |=> ##1
        flash_wait_states == $past(wb_dat_i[2:0], 2)) else $error("flash wait field");
    a_zero_start: assert property (w2c && wb_dat_i[0] && !sram_bank_a_zero_we |=>
        sram_bank_a_zero_we && sram_bank_a_zero_addr == 16'h0) else $error("clear start");
    a_zero_step: assert property (sram_bank_a_zero_we && $past(sram_bank_a_zero_we)
        && !$past(srst) |-> sram_bank_a_zero_addr == $past(sram_bank_a_zero_addr) + 16'h1)
        else $error("clear address step");
    a_zero_len: assert property ($fell(sram_bank_a_zero_we) && !$past(srst) |->
        $past(sram_bank_a_zero_addr) == `MPZC_SRAM_BANK_WORDS - 16'h1) else $error("clear length");
    a_read_busy: assert property (rd && wb_adr_i == `MPZC_ZERO_CTRL_OFS |->
        wb_dat_o[0] == $past(sram_bank_a_zero_we)) else $error("busy bit read");
    a_reserved_zero: assert property (rd |-> (wb_dat_o & (wb_adr_i == `MPZC_CLK_CTRL_OFS ?
        32'hffff_c0e8 : 32'hffff_ffe0)) == 32'h0) else $error("reserved bits");
endmodule : mpzc_props

bind mpzc_top mpzc_props u_props (.sys_clk, .srst, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .sram_pair_a_retention_enable, .sram_wait_state_enable,
    .flash_wait_states, .sram_bank_a_zero_we, .sram_bank_a_zero_addr);

/* verification/mpzc_mem_model.sv */
// Array model that takes zero writes, counting them and checking the address walk.
// Assumes one zero write per clock while zero_we is high.
`timescale 1ns/10ps
module mpzc_mem_model (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic zero_we,
    input wire logic [15:0] zero_addr,
    output logic [16:0] writes,
    output logic order_err
);
    logic [15:0] pos;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            writes <= 17'h0;
            pos <= 16'h0;
            order_err <= 1'h0;
        end else if (zero_we) begin
            writes <= writes + 17'h1;
            pos <= pos + 16'h1;
            order_err <= order_err | (zero_addr != pos);
        end else begin
            pos <= 16'h0;
        end
    end
endmodule : mpzc_mem_model

/* verification/test_memory_power_zeroize_control.sv */
// Self-checking bench for the memory power and zeroize control block.
// Assumes the design files and the array model are compiled before it.
`timescale 1ns/10ps
`include "mpzc_defs.svh"
module test_memory_power_zeroize_control;
    typedef struct packed {logic we; logic [7:0] adr; logic [3:0] sel; logic [31:0] dat;
        logic [31:0] rd; logic [9:0] pins;} mpzc_row_s;
    logic sys_clk = 1'h0;
    logic srst = 1'h1;
    logic wb_cyc_i = 1'h0;
    logic wb_stb_i = 1'h0;
    logic wb_we_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [9:0] pins;
    logic [4:0] zwe;
    logic [4:0][15:0] zad;
    logic [4:0][16:0] writes;
    logic [4:0] oerr;
    logic [31:0] rd;
    int n_errors = 0;
    int cmp_count = 0;
    mpzc_row_s rows [10] = '{'{1'h0, 8'h28, 4'hf, 32'h0, 32'h15, 10'h00d},
        '{1'h1, 8'h28, 4'hf, 32'hffff_ffff, 32'h0, 10'h3ff},
        '{1'h0, 8'h28, 4'hf, 32'h0, 32'h3f17, 10'h3ff},
        '{1'h1, 8'h28, 4'h1, 32'h2a10, 32'h0, 10'h3f8},
        '{1'h1, 8'h28, 4'h2, 32'h0, 32'h0, 10'h008},
        '{1'h1, 8'h28, 4'hf, 32'h1507, 32'h0, 10'h157},
        '{1'h0, 8'h28, 4'hf, 32'h0, 32'h1507, 10'h157},
        '{1'h1, 8'h10, 4'hf, 32'hffff_ffff, 32'h0, 10'h157},
        '{1'h0, 8'h10, 4'hf, 32'h0, 32'h0, 10'h157},
        '{1'h0, 8'h2c, 4'hf, 32'h0, 32'h0, 10'h157}};
    mpzc_top uut (.sys_clk(sys_clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rom_retention_enable(pins[9]),
        .icache_retention_enable(pins[8]), .sram_pair_d_retention_enable(pins[7]),
        .sram_pair_c_retention_enable(pins[6]), .sram_pair_b_retention_enable(pins[5]),
        .sram_pair_a_retention_enable(pins[4]), .sram_wait_state_enable(pins[3]),
        .flash_wait_states(pins[2:0]), .sram_bank_a_zero_we(zwe[0]),
        .sram_bank_a_zero_addr(zad[0]), .sram_bank_b_zero_we(zwe[1]),
        .sram_bank_b_zero_addr(zad[1]), .sram_bank_c_zero_we(zwe[2]),
        .sram_bank_c_zero_addr(zad[2]), .checkbit_zero_we(zwe[3]), .checkbit_zero_addr(zad[3]),
        .icache_zero_we(zwe[4]), .icache_zero_addr(zad[4]));
    for (genvar i = 0; i < 5; i++) begin : g_mem
        mpzc_mem_model u_mem (.sys_clk(sys_clk), .srst(srst), .zero_we(zwe[i]),
            .zero_addr(zad[i]), .writes(writes[i]), .order_err(oerr[i]));
    end
    always #2 sys_clk = ~sys_clk;
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic close_out;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    // The request is held until ack is seen at an edge; only then is it released.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
            input logic [31:0] dat);
        int n;
        n = 0;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 40);
        if (n >= 40) begin
            n_errors++;
            close_out();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        @(posedge sys_clk);
    endtask : wb
    initial begin
        repeat (5) @(posedge sys_clk);
        srst <= 1'h0;
        @(posedge sys_clk);
        foreach (rows[i]) begin
            wb(rows[i].we, rows[i].adr, rows[i].sel, rows[i].dat);
            if (!rows[i].we) chk("read data", rd, rows[i].rd);
            @(posedge sys_clk);
            chk("level pins", {22'h0, pins}, {22'h0, rows[i].pins});
        end
        $display("test register rows done");
        for (int v = 0; v < 8; v++) begin
            wb(1'h1, 8'h28, 4'h1, v);
            @(posedge sys_clk);
            chk("flash wait", {29'h0, pins[2:0]}, v);
        end
        $display("test flash field done");
        wb(1'h1, 8'h2c, 4'hf, 32'h1f);
        wb(1'h0, 8'h2c, 4'hf, 32'h0);
        chk("busy bits", rd, 32'h1f);
        wb(1'h1, 8'h2c, 4'hf, 32'h0);
        wb(1'h1, 8'h2c, 4'hf, 32'h1);
        wb(1'h0, 8'h2c, 4'hf, 32'h0);
        chk("busy kept", rd, 32'h1f);
        for (int k = 0; k < 20000 && rd !== 32'h0; k++) wb(1'h0, 8'h2c, 4'hf, 32'h0);
        chk("clear done", rd, 32'h0);
        if (rd !== 32'h0) close_out();
        for (int i = 0; i < 5; i++) chk("array writes", {15'h0, writes[i]}, i == 3 ?
            `MPZC_CHECKBIT_WORDS : i == 4 ? `MPZC_ICACHE_WORDS : `MPZC_SRAM_BANK_WORDS);
        chk("address walk", {27'h0, oerr}, 32'h0);
        $display("test zeroize done");
        wb(1'h1, 8'h28, 4'hf, 32'h2a12);
        wb(1'h1, 8'h2c, 4'hf, 32'h1f);
        srst <= 1'h1;
        repeat (5) @(posedge sys_clk);
        srst <= 1'h0;
        @(posedge sys_clk);
        chk("reset pins", {22'h0, pins}, 32'h00d);
        wb(1'h0, 8'h2c, 4'hf, 32'h0);
        chk("reset busy", rd, 32'h0);
        wb(1'h0, 8'h28, 4'hf, 32'h0);
        chk("reset register", rd, 32'h15);
        $display("test mid-run reset done");
        close_out();
    end
endmodule : test_memory_power_zeroize_control
